// ===== core/ugpio_regs.vh
`ifndef UGPIO_REGS_VH
`define UGPIO_REGS_VH

// Register indices; byte address is four times the index
`define UG_IDX_DIR0     16'hFF20
`define UG_IDX_DIR1     16'hFF21
`define UG_IDX_DIR2     16'hFF22
`define UG_IDX_DIR3     16'hFF23
`define UG_IDX_DIR4     16'hFF24
`define UG_IDX_DIR6     16'hFF26
`define UG_IDX_DIR7     16'hFF27
`define UG_IDX_DIR12    16'hFF2C
`define UG_IDX_DIR14    16'hFF2E
`define UG_IDX_LAT7     16'hFF07
`define UG_IDX_LAT12    16'hFF0C
`define UG_IDX_LAT13    16'hFF0D
`define UG_IDX_LAT14    16'hFF0E
`define UG_IDX_PU7      16'hFF37
`define UG_IDX_PORT12_PULLUP_ENABLE     16'hFF3C
`define UG_IDX_PORT14_PULLUP_ENABLE     16'hFF3E
`define UG_IDX_CKSEL    16'hFF9F

// Reset values
`define UG_DIR_RESET    8'hFF
`define UG_LAT_RESET    8'h00
`define UG_PU_RESET     8'h00
`define UG_CKSEL_RESET  8'h00

// Implemented bits per direction register, port twelve pull-up enable and clock pin mode select
`define UG_MASK_P0      8'h0F
`define UG_MASK_P1      8'hFF
`define UG_MASK_P2      8'hFF
`define UG_MASK_P3      8'h0F
`define UG_MASK_P4      8'h03
`define UG_MASK_P6      8'h0F
`define UG_MASK_P7      8'hFF
`define UG_MASK_P12     8'h1F
`define UG_MASK_P14     8'h01
`define UG_MASK_PORT12_PULLUP_ENABLE    8'h01
`define UG_MASK_CKSEL   8'h0F

// Direction bank order: 0,1,2,3,4,6,7,12,14 (entry 8 first in the lists)
`define UG_NUM_DIR      9
`define UG_DIR_IDX_LIST {`UG_IDX_DIR14, `UG_IDX_DIR12, `UG_IDX_DIR7, `UG_IDX_DIR6, \
                         `UG_IDX_DIR4, `UG_IDX_DIR3, `UG_IDX_DIR2, `UG_IDX_DIR1, `UG_IDX_DIR0}
`define UG_DIR_MASK_LIST {`UG_MASK_P14, `UG_MASK_P12, `UG_MASK_P7, `UG_MASK_P6, \
                          `UG_MASK_P4, `UG_MASK_P3, `UG_MASK_P2, `UG_MASK_P1, `UG_MASK_P0}
`define UG_DIR_SLOT_P7  6
`define UG_DIR_SLOT_P12 7
`define UG_DIR_SLOT_P14 8

// Clock pin mode select fields
`define UG_CK_MAIN_OSC  0
`define UG_CK_MAIN_EXT  1
`define UG_CK_SUB_OSC   2
`define UG_CK_SUB_EXT   3

// Port twelve pin positions
`define UG_P12_PULL     0
`define UG_P12_X1       1
`define UG_P12_X2       2
`define UG_P12_XT1      3
`define UG_P12_XT2      4

`endif

// ===== core/ugpio_top.v
// Contract
// R1 - Port seven has eight latched pins, each direction set by its own bit.
// R2 - Port seven input pins get per-bit pull-ups from the pull-up register.
// R3 - Port seven pin levels also feed the key-return inputs.
// R4 - Reset puts all port seven pins in input mode.
// R5 - Port twelve has five latched pins, each direction set by its own bit.
// R6 - Only port twelve pin zero has a pull-up, active only as input.
// R7 - Port twelve offers interrupt, voltage-detect, resonator and external clock uses.
// R8 - Reset puts all port twelve pins in input mode.
// R9 - Clock pin mode select resets to zero; software must select clock modes.
// R10 - Selected clock modes take over pins regardless of direction and latch bits.
// R11 - Port thirteen is one output-only pin without input mode.
// R12 - Port thirteen drives low during reset, usable as external reset.
// R13 - Port fourteen has latch, direction bit and input-only pull-up.
// R14 - Port fourteen also serves as interrupt input and clock output.
// R15 - Reset puts port fourteen in input mode.
// R16 - Direction registers accept byte writes and set each pin individually.
// R17 - Every direction register resets to all ones.
// R18 - Direction zero enables the output buffer; one makes the pin input.
// R19 - Latch read returns pin level for inputs, latch for outputs.
// R20 - Latch and pull-up registers reset to zero.
// R21 - No pull-up on output pins or alternate-function outputs.
// R22 - Direction bits without pins read one and ignore writes.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`include "ugpio_regs.vh"

module ugpio_top #(
   parameter ADDR_WIDTH = 18
) (
   // APB slave
   input  wire                  pclk,
   input  wire                  presetn,
   input  wire [ADDR_WIDTH-1:0] paddr,
   input  wire                  psel,
   input  wire                  penable,
   input  wire                  pwrite,
   input  wire [31:0]           pwdata,
   input  wire [3:0]            pstrb,
   output reg  [31:0]           prdata,
   output reg                   pready,
   output reg                   pslverr,
   // Port seven pins
   input  wire [7:0]            port7_in,
   output reg  [7:0]            port7_out,
   output reg  [7:0]            port7_oe,
   output reg  [7:0]            port7_pullup_on,
   // Port twelve pins
   input  wire [4:0]            port12_in,
   output reg  [4:0]            port12_out,
   output reg  [4:0]            port12_oe,
   output reg                   port12_pin_zero_pullup_on,
   // Port thirteen pin
   output reg                   port13_output_pin,
   output reg                   port13_oe,
   // Port fourteen pin
   input  wire                  port14_pin_in,
   output reg                   port14_pin_out,
   output reg                   port14_oe,
   output reg                   port14_pullup_on,
   // Alternate functions
   input  wire                  clock_output_enable,
   input  wire                  clock_output_value,
   output reg  [7:0]            key_return,
   output reg                   external_interrupt0,
   output reg                   external_interrupt14,
   output reg                   external_voltage_detect_input,
   output reg                   main_resonator_enable,
   output reg                   sub_resonator_enable,
   output reg                   main_external_clock_input,
   output reg                   sub_external_clock_input,
   // Direction bits of the lower ports 0,1,2,3,4,6
   output reg  [47:0]           lower_direction
);

   localparam [16*`UG_NUM_DIR-1:0] DIR_IDX  = `UG_DIR_IDX_LIST;
   localparam [8*`UG_NUM_DIR-1:0]  DIR_MASK = `UG_DIR_MASK_LIST;
   // Named so that narrower registers can take a slice of the reset byte
   localparam [7:0]                LAT_RESET   = `UG_LAT_RESET;
   localparam [7:0]                PU_RESET    = `UG_PU_RESET;
   localparam [7:0]                CKSEL_RESET = `UG_CKSEL_RESET;

   wire [15:0] reg_index;
   wire        aligned;
   wire        setup_phase;
   wire        write_fire;

   assign reg_index   = paddr[17:2];
   assign aligned     = (paddr[1:0] == 2'b00);
   assign setup_phase = psel & ~penable;
   // Only the low byte lane carries register data
   assign write_fire  = psel & penable & pready & pwrite & pstrb[0];

   wire [8*`UG_NUM_DIR-1:0] direction;
   wire [`UG_NUM_DIR-1:0]   hit_dir;
   reg  [7:0]               port7_latch;
   reg  [4:0]               port12_latch;
   reg                      port13_latch;
   reg                      port14_latch;
   reg  [7:0]               port7_pullup_enable;
   reg                      port12_pullup_enable;
   reg                      port14_pullup_enable;
   reg  [3:0]               clock_pin_mode_select;

   // Direction register bank
   genvar gi;
   generate
      for (gi = 0; gi < `UG_NUM_DIR; gi = gi + 1)
      begin : g_dir
         reg [7:0] dir_q;
         assign hit_dir[gi] = aligned & (reg_index == DIR_IDX[16*gi +: 16]);
         assign direction[8*gi +: 8] = dir_q;
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               dir_q <= `UG_DIR_RESET; // R4 R8 R15 R17
            else if (write_fire && hit_dir[gi])
               // Pinless bits are forced back to one
               dir_q <= pwdata[7:0] | ~DIR_MASK[8*gi +: 8]; // R16 R22
         end
      end
   endgenerate

   wire [7:0] dir7;
   wire [4:0] dir12;
   wire       dir14;
   assign dir7  = direction[8*`UG_DIR_SLOT_P7 +: 8]; // R1
   assign dir12 = direction[8*`UG_DIR_SLOT_P12 +: 5]; // R5
   assign dir14 = direction[8*`UG_DIR_SLOT_P14];

   wire hit_lat7;
   wire hit_lat12;
   wire hit_lat13;
   wire hit_lat14;
   wire hit_pu7;
   wire hit_port12_pullup_enable;
   wire hit_port14_pullup_enable;
   wire hit_cksel;
   assign hit_lat7  = aligned & (reg_index == `UG_IDX_LAT7);
   assign hit_lat12 = aligned & (reg_index == `UG_IDX_LAT12);
   assign hit_lat13 = aligned & (reg_index == `UG_IDX_LAT13);
   assign hit_lat14 = aligned & (reg_index == `UG_IDX_LAT14);
   assign hit_pu7   = aligned & (reg_index == `UG_IDX_PU7);
   assign hit_port12_pullup_enable  = aligned & (reg_index == `UG_IDX_PORT12_PULLUP_ENABLE);
   assign hit_port14_pullup_enable  = aligned & (reg_index == `UG_IDX_PORT14_PULLUP_ENABLE);
   assign hit_cksel = aligned & (reg_index == `UG_IDX_CKSEL);

   // Latches, pull-up enables and clock pin mode select
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port7_latch           <= LAT_RESET; // R20
         port12_latch          <= LAT_RESET[4:0];
         port13_latch          <= LAT_RESET[0]; // R12
         port14_latch          <= LAT_RESET[0];
         port7_pullup_enable   <= PU_RESET; // R20
         port12_pullup_enable  <= PU_RESET[0];
         port14_pullup_enable  <= PU_RESET[0];
         clock_pin_mode_select <= CKSEL_RESET[3:0]; // R9
      end
      else if (write_fire)
      begin
         if (hit_lat7)
            port7_latch <= pwdata[7:0];
         if (hit_lat12)
            port12_latch <= pwdata[4:0];
         if (hit_lat13)
            port13_latch <= pwdata[0];
         if (hit_lat14)
            port14_latch <= pwdata[0];
         if (hit_pu7)
            port7_pullup_enable <= pwdata[7:0]; // R2
         if (hit_port12_pullup_enable)
            port12_pullup_enable <= pwdata[0]; // R6
         if (hit_port14_pullup_enable)
            port14_pullup_enable <= pwdata[0]; // R13
         if (hit_cksel)
            clock_pin_mode_select <= pwdata[3:0];
      end
   end

   // Pins claimed by the oscillator or external clock inputs
   wire       main_osc;
   wire       main_ext;
   wire       sub_osc;
   wire       sub_ext;
   wire [4:0] take12;
   wire       clkout_active;
   assign main_osc = clock_pin_mode_select[`UG_CK_MAIN_OSC];
   assign main_ext = clock_pin_mode_select[`UG_CK_MAIN_EXT];
   assign sub_osc  = clock_pin_mode_select[`UG_CK_SUB_OSC];
   assign sub_ext  = clock_pin_mode_select[`UG_CK_SUB_EXT];
   // External clock mode claims only the clock input pin of each pair
   assign take12 = {sub_osc | sub_ext, sub_osc, main_osc | main_ext, main_osc, 1'b0}; // R10
   // Clock output needs the pin in output mode to reach the buffer
   assign clkout_active = clock_output_enable & ~dir14; // R14

   // Read data: latch reads give pin level for inputs, latch for outputs; other registers read back as stored
   reg [7:0] read_byte;
   reg       read_hit;
   integer   k;
   always @*
   begin
      read_byte = 8'h00;
      read_hit  = 1'b0;
      for (k = 0; k < `UG_NUM_DIR; k = k + 1)
      begin
         if (hit_dir[k])
         begin
            read_byte = direction[8*k +: 8]; // R22
            read_hit  = 1'b1;
         end
      end
      if (hit_lat7)
      begin
         read_byte = (dir7 & port7_in) | (~dir7 & port7_latch); // R19
         read_hit  = 1'b1;
      end
      if (hit_lat12)
      begin
         read_byte = {3'b000, ((dir12 | take12) & port12_in) |
                              (~(dir12 | take12) & port12_latch)}; // R19
         read_hit  = 1'b1;
      end
      if (hit_lat13)
      begin
         read_byte = {7'b0000000, port13_latch}; // R11
         read_hit  = 1'b1;
      end
      if (hit_lat14)
      begin
         read_byte = {7'b0000000, dir14 ? port14_pin_in : port14_latch}; // R19
         read_hit  = 1'b1;
      end
      if (hit_pu7)
      begin
         read_byte = port7_pullup_enable;
         read_hit  = 1'b1;
      end
      if (hit_port12_pullup_enable)
      begin
         read_byte = {7'b0000000, port12_pullup_enable};
         read_hit  = 1'b1;
      end
      if (hit_port14_pullup_enable)
      begin
         read_byte = {7'b0000000, port14_pullup_enable};
         read_hit  = 1'b1;
      end
      if (hit_cksel)
      begin
         read_byte = {4'h0, clock_pin_mode_select};
         read_hit  = 1'b1;
      end
   end

   // APB answer: captured in setup, presented in a single access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup_phase;
         if (setup_phase)
         begin
            prdata  <= pwrite ? 32'h0000_0000 : {24'h000000, read_byte};
            pslverr <= ~read_hit;
         end
         else
         begin
            pslverr <= 1'b0;
         end
      end
   end

   // Pin drivers, one cycle behind the registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port7_out       <= 8'h00;
         port7_oe        <= 8'h00; // R4
         port7_pullup_on <= 8'h00;
      end
      else
      begin
         port7_out       <= port7_latch;
         port7_oe        <= ~dir7; // R18
         port7_pullup_on <= port7_pullup_enable & dir7; // R2 R21
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port12_out                <= 5'h00;
         port12_oe                 <= 5'h00; // R8
         port12_pin_zero_pullup_on <= 1'b0;
      end
      else
      begin
         port12_out                <= port12_latch;
         port12_oe                 <= ~dir12 & ~take12; // R18 R10
         port12_pin_zero_pullup_on <= port12_pullup_enable & dir12[`UG_P12_PULL]; // R6 R21
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port13_output_pin <= 1'b0; // R12
         port13_oe         <= 1'b1; // R11
      end
      else
      begin
         port13_output_pin <= port13_latch; // R11
         port13_oe         <= 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port14_pin_out   <= 1'b0;
         port14_oe        <= 1'b0; // R15
         port14_pullup_on <= 1'b0;
      end
      else
      begin
         port14_pin_out   <= clkout_active ? clock_output_value : port14_latch; // R14
         port14_oe        <= ~dir14; // R18 R13
         port14_pullup_on <= port14_pullup_enable & dir14 & ~clock_output_enable; // R21
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         key_return                    <= 8'h00;
         external_interrupt0           <= 1'b0;
         external_interrupt14          <= 1'b0;
         external_voltage_detect_input <= 1'b0;
         main_resonator_enable         <= 1'b0;
         sub_resonator_enable          <= 1'b0;
         main_external_clock_input     <= 1'b0;
         sub_external_clock_input      <= 1'b0;
      end
      else
      begin
         key_return                    <= port7_in; // R3
         external_interrupt0           <= port12_in[`UG_P12_PULL]; // R7
         external_voltage_detect_input <= port12_in[`UG_P12_PULL]; // R7
         external_interrupt14          <= port14_pin_in; // R14
         main_resonator_enable         <= main_osc; // R7 R10
         sub_resonator_enable          <= sub_osc;
         main_external_clock_input     <= main_ext & port12_in[`UG_P12_X2]; // R7
         sub_external_clock_input      <= sub_ext & port12_in[`UG_P12_XT2];
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lower_direction <= {6{`UG_DIR_RESET}};
      end
      else
      begin
         lower_direction <= direction[47:0];
      end
   end

endmodule // ugpio_top

// ===== verif/ugpio_pins.sv
`timescale 1ns/1ps
module ugpio_pins #(
   parameter W = 8
) (
   // Design side
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] pu,
   // Board side
   input  wire logic [W-1:0] ext,
   output logic      [W-1:0] lvl
);
   // Released lines go to the board value, or high where a pull-up holds them
   always_comb
      for (int i = 0; i < W; i++)
         lvl[i] = oe[i] ? out[i] : (pu[i] ? 1'b1 : ext[i]);
endmodule // ugpio_pins

// ===== verif/ugpio_top_sva.sv
`timescale 1ns/1ps
module ugpio_sva (
   // Bus
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   // Pins
   input wire logic [7:0] port7_in,
   input wire logic [7:0] port7_oe,
   input wire logic [7:0] port7_pullup_on,
   input wire logic [7:0] key_return,
   input wire logic [4:0] port12_oe,
   input wire logic       port12_pin_zero_pullup_on,
   input wire logic       port13_output_pin,
   input wire logic       port13_oe,
   input wire logic       port14_pin_in,
   input wire logic       port14_pullup_on,
   input wire logic       clock_output_enable,
   input wire logic       external_interrupt14
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   p13_drives_a: assert property (port13_oe) else $error("port13 not driven");
   pull_vs_out_a: assert property ((port7_pullup_on & port7_oe) == 8'h00)
      else $error("port7 pull-up on driven pin");
   p12_pull_in_a: assert property (port12_pin_zero_pullup_on |-> !port12_oe[0])
      else $error("port12 pull-up on driven pin");
   p14_pull_clk_a: assert property (clock_output_enable |=> !port14_pullup_on)
      else $error("port14 pull-up during clock output");
   key_follow_a: assert property ($past(presetn) |-> key_return == $past(port7_in))
      else $error("key return mismatch");
   int14_follow_a: assert property ($past(presetn) |->
      external_interrupt14 == $past(port14_pin_in)) else $error("interrupt 14 mismatch");
   apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("ready not one cycle after setup");
   err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
   reset_pins_a: assert property (@(posedge pclk) disable iff (1'b0) !presetn |->
      !port13_output_pin && port7_oe == 8'h00 && port12_oe == 5'h00)
      else $error("pins not quiet in reset");
endmodule // ugpio_sva

bind ugpio_top ugpio_sva ugpio_sva_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .port7_in(port7_in),
   .port7_oe(port7_oe), .port7_pullup_on(port7_pullup_on), .key_return(key_return),
   .port12_oe(port12_oe), .port12_pin_zero_pullup_on(port12_pin_zero_pullup_on),
   .port13_output_pin(port13_output_pin), .port13_oe(port13_oe),
   .port14_pin_in(port14_pin_in), .port14_pullup_on(port14_pullup_on),
   .clock_output_enable(clock_output_enable), .external_interrupt14(external_interrupt14));

// ===== verif/test_upper_gpio_ports_direction.sv
`timescale 1ns/1ps
`include "ugpio_regs.vh"
module test_upper_gpio_ports_direction;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, coe, cval;
   logic [17:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic [7:0]  p7_in, p7_out, p7_oe, p7_pu, p7_ext, key_ret;
   logic [4:0]  p12_in, p12_out, p12_oe, p12_ext;
   logic        p12_pu, p13_pin, p13_oe, p14_in, p14_out, p14_oe, p14_pu, p14_ext;
   logic        res_m, res_s, ext_m, ext_s, int14, ext_int0, evd;
   logic [47:0] lower_dir;
   int          err_count, n_checks;
   logic [143:0] dirs = `UG_DIR_IDX_LIST;
   logic [71:0]  masks = `UG_DIR_MASK_LIST;

   ugpio_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port7_in(p7_in), .port7_out(p7_out),
      .port7_oe(p7_oe), .port7_pullup_on(p7_pu), .port12_in(p12_in), .port12_out(p12_out),
      .port12_oe(p12_oe), .port12_pin_zero_pullup_on(p12_pu), .port13_output_pin(p13_pin),
      .port13_oe(p13_oe), .port14_pin_in(p14_in), .port14_pin_out(p14_out),
      .port14_oe(p14_oe), .port14_pullup_on(p14_pu), .clock_output_enable(coe),
      .clock_output_value(cval), .key_return(key_ret), .external_interrupt0(ext_int0),
      .external_interrupt14(int14), .external_voltage_detect_input(evd),
      .main_resonator_enable(res_m), .sub_resonator_enable(res_s),
      .main_external_clock_input(ext_m), .sub_external_clock_input(ext_s),
      .lower_direction(lower_dir));
   ugpio_pins #(.W(8)) pins7_u (.out(p7_out), .oe(p7_oe), .pu(p7_pu), .ext(p7_ext),
      .lvl(p7_in));
   ugpio_pins #(.W(5)) pins12_u (.out(p12_out), .oe(p12_oe), .pu({4'h0, p12_pu}),
      .ext(p12_ext), .lvl(p12_in));
   ugpio_pins #(.W(1)) pins14_u (.out(p14_out), .oe(p14_oe), .pu(p14_pu), .ext(p14_ext),
      .lvl(p14_in));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
      paddr <= {idx, 2'b00};
      pwrite <= wr;
      pwdata <= {24'h0, wd};
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [15:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      apb(1'b1, idx, d, r, e);
   endtask

   task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic       e;
      apb(1'b0, idx, 8'h00, r, e);
      chk($sformatf("reg %h", idx), {40'h0, r}, {40'h0, exp});
   endtask

   task automatic t_reset;
      for (int i = 0; i < 9; i++)
         rd_chk(dirs[16*i +: 16], 8'hFF);
      rd_chk(`UG_IDX_LAT7, 8'h3C);
      rd_chk(`UG_IDX_PU7, 8'h00);
      rd_chk(`UG_IDX_CKSEL, 8'h00);
      chk("oe", {p7_oe, p12_oe, p14_oe}, 14'h0000);
      chk("lower dir", lower_dir, 48'hFFFF_FFFF_FFFF);
      $display("test reset done");
   endtask

   task automatic t_dir;
      logic [47:0] exp;
      for (int i = 0; i < 9; i++)
      begin
         wr(dirs[16*i +: 16], 8'h00);
         rd_chk(dirs[16*i +: 16], ~masks[8*i +: 8]);
      end
      for (int i = 0; i < 6; i++)
         exp[8*i +: 8] = ~masks[8*i +: 8];
      repeat (2) @(posedge pclk);
      chk("lower dir", lower_dir, exp);
      chk("oe", {p7_oe, p12_oe, p14_oe}, 14'h3FFF);
      $display("test direction done");
   endtask

   task automatic t_latch;
      wr(`UG_IDX_DIR7, 8'h0F);
      wr(`UG_IDX_LAT7, 8'hA5);
      wr(`UG_IDX_PU7, 8'hFF);
      wr(`UG_IDX_DIR12, 8'h1F);
      wr(`UG_IDX_PORT12_PULLUP_ENABLE, 8'hFF);
      repeat (2) @(posedge pclk);
      chk("p7 out", p7_out, 8'hA5);
      chk("p7 oe", p7_oe, 8'hF0);
      chk("p7 pull", p7_pu, 8'h0F);
      chk("key", key_ret, 8'hAF);
      chk("p12 pull", p12_pu, 1'b1);
      rd_chk(`UG_IDX_LAT7, 8'hAF);
      rd_chk(`UG_IDX_PORT12_PULLUP_ENABLE, 8'h01);
      $display("test latch done");
   endtask

   task automatic t_clock;
      p12_ext <= 5'h14;
      wr(`UG_IDX_DIR12, 8'h00);
      wr(`UG_IDX_LAT12, 8'h0B);
      wr(`UG_IDX_CKSEL, 8'h0F);
      repeat (2) @(posedge pclk);
      chk("p12 oe", p12_oe, 5'h01);
      chk("clock pins", {res_m, res_s, ext_m, ext_s}, 4'hF);
      chk("p12 out", p12_out, 5'h0B);
      chk("p12 pin0 uses", {ext_int0, evd}, 2'h3);
      rd_chk(`UG_IDX_LAT12, 8'h15);
      wr(`UG_IDX_CKSEL, 8'h00);
      repeat (2) @(posedge pclk);
      chk("p12 oe", p12_oe, 5'h1F);
      rd_chk(`UG_IDX_LAT12, 8'h0B);
      $display("test clock done");
   endtask

   task automatic t_p13;
      wr(`UG_IDX_LAT13, 8'h01);
      repeat (2) @(posedge pclk);
      chk("p13", {p13_pin, p13_oe}, 2'h3);
      presetn <= 1'b0;
      @(posedge pclk);
      @(posedge pclk);
      chk("p13 reset", {p13_pin, p7_oe}, 9'h000);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(`UG_IDX_DIR14, 8'hFF);
      $display("test reset pin done");
   endtask

   task automatic t_p14;
      wr(`UG_IDX_DIR14, 8'h00);
      wr(`UG_IDX_PORT14_PULLUP_ENABLE, 8'h01);
      coe <= 1'b1;
      cval <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("p14 clk", {p14_out, p14_oe, p14_pu}, 3'h6);
      coe <= 1'b0;
      wr(`UG_IDX_DIR14, 8'hFF);
      repeat (2) @(posedge pclk);
      chk("p14 in", {p14_out, p14_oe, p14_pu, int14}, 4'h3);
      rd_chk(`UG_IDX_LAT14, 8'h01);
      $display("test port14 done");
   endtask

   task automatic t_bad;
      logic [7:0] r;
      logic       e;
      apb(1'b0, 16'hFF50, 8'h00, r, e);
      chk("unmapped", {r, e}, 9'h001);
      pstrb <= 4'h0;
      wr(`UG_IDX_DIR7, 8'h00);
      pstrb <= 4'hF;
      rd_chk(`UG_IDX_DIR7, 8'hFF);
      $display("test refused done");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      #50000;
      err_count++;
      wrap_up();
   end

   initial
   begin
      {presetn, psel, penable, pwrite, coe, cval} <= 6'h00;
      {paddr, pwdata, pstrb} = {18'h0, 32'h0, 4'hF};
      {p7_ext, p12_ext, p14_ext} = {8'h3C, 5'h0A, 1'b0};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_dir();
      t_latch();
      t_clock();
      t_p13();
      t_p14();
      t_bad();
      wrap_up();
   end
endmodule // test_upper_gpio_ports_direction
